// >>> rtl/scr_pkg.sv
// Constants shared by the card reader block and its concurrent checker.
// Assumes a 200 MHz block clock; the tick count and the 3.5 and 7.1 MHz divisors are derived from it here.
package scr_pkg;

    // ------------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int TICK_TIME_NS   = 1000;
    localparam int TICK_CYCLES    = (TICK_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int TICK_W         = 8;

    // ------------------------------------------------------------------
    // Card clock selection and divisors (in block clock cycles)
    // ------------------------------------------------------------------
    localparam logic [1:0] CLKSEL_STOP = 2'h0;
    localparam logic [1:0] CLKSEL_3M5  = 2'h1;
    localparam logic [1:0] CLKSEL_7M1  = 2'h2;
    localparam logic [1:0] CLKSEL_96M  = 2'h3;
    localparam int CLK_3M5_KHZ    = 3500;
    localparam int CLK_7M1_KHZ    = 7100;
    localparam int CLK_96M_KHZ    = 96000;
    localparam int REF_KHZ        = 1000000000 / CLK_PERIOD_PS;
    localparam int DIV_W          = 12;
    localparam logic [DIV_W-1:0] DIV_3M5 =
        DIV_W'((REF_KHZ + CLK_3M5_KHZ / 2) / CLK_3M5_KHZ);
    localparam logic [DIV_W-1:0] DIV_7M1 =
        DIV_W'((REF_KHZ + CLK_7M1_KHZ / 2) / CLK_7M1_KHZ);
    localparam logic [DIV_W-1:0] DIV_MIN = 12'h002;

    // ------------------------------------------------------------------
    // Sequencer timing
    // ------------------------------------------------------------------
    localparam int TIMER_W        = 16;
    localparam logic [TIMER_W-1:0] CLK_SETTLE_TICKS = 16'h0001;
    localparam int SYNC_STAGES    = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_POWER_N  = 1'b1;
    localparam logic RST_CARD_RST = 1'b0;
    localparam logic RST_SIN      = 1'b1;

    // ------------------------------------------------------------------
    // Sequencer states, Gray coded along activation then deactivation
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SCR_OFF       = 3'h0,
        SCR_CHARGE    = 3'h1,
        SCR_CLK_ON    = 3'h3,
        SCR_ACTIVE    = 3'h2,
        SCR_DEACT     = 3'h6,
        SCR_DISCHARGE = 3'h7
    } scr_state_e;

endpackage

// >>> rtl/scr_buf.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; the drain may stall and the buffer fills honestly.
module scr_buf #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic             wr_reg, wr_next;
    logic             rd_reg, rd_next;
    logic [1:0]       cnt_reg, cnt_next;
    logic             push, pop;

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next pointers and count; push and pop may share a cycle
    always_comb begin
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        if (push) begin
            mem_next[wr_reg] = in_data;
        end
        wr_next  = push ? ~wr_reg : wr_reg;
        rd_next  = pop ? ~rd_reg : rd_reg;
        cnt_next = cnt_reg + 2'(push) - 2'(pop);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_reg     <= 1'b0;
            rd_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
        end else begin
            mem_reg    <= mem_next;
            wr_reg     <= wr_next;
            rd_reg     <= rd_next;
            cnt_reg    <= cnt_next;
        end
    end

endmodule

// >>> rtl/scr_top.sv
// Card reader block: reuses one of two UARTs' modem lines to run an
// ISO 7816 card socket, makes the card clock and sequences power.
// Assumes both UARTs run on ref_clk; card pins are asynchronous.
//
// Operation
// - Serial port 1 or 2 selectable for card mode
// - Divider clocks gated off while interface inactive
// - DTR# powers switch, RTS# resets, DCD# detects
// - Card presence change reflected on DCD#
// - Programmable charge/discharge time, automatic ordering
// - Card signals enabled only after charge time
// - Deactivate signals, release power, then discharge wait
// - Removal or DTR# deassert starts deactivation
// - Card clock duty between 45 and 55 percent
// - Default rate card clock over 372, 1-5 MHz
// - Clock select: stop, 3.5, 7.1, 96/divisor
// - Receive mode, clock first, then data enabled
// - Card reset is inverse of RTS#
// - Hardware enforces ordering despite sloppy driver timing
// - Only asynchronous character transfer supported
// - Card I/O half-duplex, no transmit/receive overlap; receive still takes the last 4 cycles of own transmit
module scr_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Mode and configuration
    input  wire logic        card_mode_en,
    input  wire logic        port_select,
    input  wire logic [1:0]  card_clock_select,
    input  wire logic [7:0]  high_clock_divisor,
    input  wire logic [15:0] charge_time,
    input  wire logic [15:0] discharge_time,
    // UART modem and serial lines, one pair per port
    input  wire logic [1:0]  uart_sout,
    input  wire logic [1:0]  uart_dtr_n,
    input  wire logic [1:0]  uart_rts_n,
    output logic      [1:0]  uart_dcd_n,
    output logic      [1:0]  uart_sin,
    input  wire logic        uart_rx_ready,
    // Card socket
    input  wire logic        card_present_n,
    output logic             card_power_switch_n,
    output logic             card_reset,
    output logic             card_clock,
    input  wire logic        card_io_in,
    output logic             card_io_out,
    output logic             card_io_oe,
    // Status
    output logic             card_active,
    output logic             clocks_running
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int SYNC_W = scr_pkg::SYNC_STAGES;
    logic [SYNC_W-1:0] pres_sync_reg, io_sync_reg;
    logic pres_f_reg, pres_f_next;
    logic io_f_reg, io_f_next;

    // A level counts only once stages two and three agree
    always_comb begin
        pres_f_next = pres_f_reg;
        io_f_next   = io_f_reg;
        if (pres_sync_reg[1] == pres_sync_reg[2]) begin
            pres_f_next = pres_sync_reg[2];
        end
        if (io_sync_reg[1] == io_sync_reg[2]) begin
            io_f_next = io_sync_reg[2];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pres_sync_reg <= '1;
            io_sync_reg   <= '1;
            pres_f_reg    <= 1'b1;
            io_f_reg      <= 1'b1;
        end else begin
            pres_sync_reg <= {pres_sync_reg[SYNC_W-2:0], card_present_n};
            io_sync_reg   <= {io_sync_reg[SYNC_W-2:0], card_io_in};
            pres_f_reg    <= pres_f_next;
            io_f_reg      <= io_f_next;
        end
    end

    // ------------------------------------------------------------------
    // Port selection
    // ------------------------------------------------------------------
    logic sel_dtr_n, sel_rts_n, sel_sout;
    logic card_in, power_req;

    assign sel_dtr_n = uart_dtr_n[port_select];
    assign sel_rts_n = uart_rts_n[port_select];
    assign sel_sout  = uart_sout[port_select];
    assign card_in   = ~pres_f_reg;
    assign power_req = card_mode_en && !sel_dtr_n && card_in;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    scr_pkg::scr_state_e state_reg, state_next;
    logic [scr_pkg::TIMER_W-1:0] timer_reg, timer_next;
    logic [scr_pkg::TICK_W-1:0]  tick_reg, tick_next;
    logic tick;
    logic power_n_reg, power_n_next;
    logic reset_reg, reset_next;
    logic clk_en, io_en;

    assign tick = (tick_reg == scr_pkg::TICK_W'(scr_pkg::TICK_CYCLES - 1));

    // Timer counts microsecond ticks of the block clock
    always_comb begin
        state_next   = state_reg;
        timer_next   = timer_reg;
        power_n_next = power_n_reg;
        reset_next   = reset_reg;
        tick_next    = (state_reg == scr_pkg::SCR_OFF || tick) ?
                       '0 : tick_reg + 1'b1;
        if (tick && timer_reg != '0) begin
            timer_next = timer_reg - 1'b1;
        end
        case (state_reg)
            scr_pkg::SCR_OFF: begin
                power_n_next = 1'b1;
                reset_next   = 1'b0;
                if (power_req) begin
                    state_next   = scr_pkg::SCR_CHARGE;
                    power_n_next = 1'b0;
                    timer_next   = charge_time;
                end
            end
            scr_pkg::SCR_CHARGE: begin
                if (!power_req) begin
                    state_next = scr_pkg::SCR_DEACT;
                end else if (timer_reg == '0) begin
                    state_next = scr_pkg::SCR_CLK_ON;
                    timer_next = scr_pkg::CLK_SETTLE_TICKS;
                end
            end
            scr_pkg::SCR_CLK_ON: begin
                // Reset held low while clock starts, whatever RTS# says
                reset_next = 1'b0;
                if (!power_req) begin
                    state_next = scr_pkg::SCR_DEACT;
                end else if (timer_reg == '0) begin
                    state_next = scr_pkg::SCR_ACTIVE;
                end
            end
            scr_pkg::SCR_ACTIVE: begin
                reset_next = ~sel_rts_n;
                if (!power_req) begin
                    state_next = scr_pkg::SCR_DEACT;
                    reset_next = 1'b0;
                end
            end
            scr_pkg::SCR_DEACT: begin
                // Signals already off; now release the power switch
                reset_next   = 1'b0;
                power_n_next = 1'b1;
                // Fresh tick phase so the full discharge span is kept
                tick_next    = '0;
                timer_next   = discharge_time;
                state_next   = scr_pkg::SCR_DISCHARGE;
            end
            scr_pkg::SCR_DISCHARGE: begin
                if (timer_reg == '0) begin
                    state_next = scr_pkg::SCR_OFF;
                end
            end
            default: begin
                state_next   = scr_pkg::SCR_OFF;
                power_n_next = 1'b1;
                reset_next   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg   <= scr_pkg::SCR_OFF;
            timer_reg   <= '0;
            tick_reg    <= '0;
            power_n_reg <= scr_pkg::RST_POWER_N;
            reset_reg   <= scr_pkg::RST_CARD_RST;
        end else begin
            state_reg   <= state_next;
            timer_reg   <= timer_next;
            tick_reg    <= tick_next;
            power_n_reg <= power_n_next;
            reset_reg   <= reset_next;
        end
    end

    // Dropping the request stops clock and I/O before the supply goes
    assign clk_en = power_req && ((state_reg == scr_pkg::SCR_CLK_ON) ||
                    (state_reg == scr_pkg::SCR_ACTIVE));
    assign io_en  = power_req && (state_reg == scr_pkg::SCR_ACTIVE);

    // ------------------------------------------------------------------
    // Card clock divider
    // ------------------------------------------------------------------
    logic [scr_pkg::DIV_W-1:0] div_sel, div_cnt_reg, div_cnt_next;
    logic [scr_pkg::DIV_W+4:0] div_hi_calc;
    logic cclk_reg, cclk_next;
    logic run;

    // 96 MHz over divisor, rescaled to block clock cycles
    assign div_hi_calc = ((17'(high_clock_divisor) * 17'h19) + 17'h6) /
                         17'hc;

    always_comb begin
        case (card_clock_select)
            scr_pkg::CLKSEL_3M5: div_sel = scr_pkg::DIV_3M5;
            scr_pkg::CLKSEL_7M1: div_sel = scr_pkg::DIV_7M1;
            scr_pkg::CLKSEL_96M: begin
                div_sel = div_hi_calc[scr_pkg::DIV_W-1:0];
                if (div_sel < scr_pkg::DIV_MIN) begin
                    div_sel = scr_pkg::DIV_MIN;
                end
            end
            default: div_sel = '0;
        endcase
    end

    // Counter cleared when stopped, which gates the divider's toggling
    assign run = clk_en && (card_clock_select != scr_pkg::CLKSEL_STOP);

    // High for half the period rounded down: odd divisors stay near 50%
    always_comb begin
        div_cnt_next = '0;
        cclk_next    = 1'b0;
        if (run) begin
            div_cnt_next = (div_cnt_reg >= div_sel - 1'b1) ?
                           '0 : div_cnt_reg + 1'b1;
            cclk_next    = (div_cnt_next < (div_sel >> 1));
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= '0;
            cclk_reg    <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            cclk_reg    <= cclk_next;
        end
    end

    // ------------------------------------------------------------------
    // Card I/O path, half-duplex
    // ------------------------------------------------------------------
    logic io_oe_next, io_oe_reg;
    logic rx_valid, rx_data, buf_in_ready;
    logic sin_reg, sin_next;
    logic [1:0] dcd_reg, dcd_next;

    // Open-drain: pull low only while transmitting a zero
    assign io_oe_next = io_en && !sel_sout;

    // Own transmission is masked until one cycle after it ends; its last 4 cycles still echo through the synchroniser
    assign rx_valid = io_en && sel_sout && !io_oe_reg;
    assign rx_data  = io_f_reg;

    logic buf_out_valid, buf_out_data;

    scr_buf #(
        .WIDTH (1)
    ) u_rx_buf (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (rx_valid),
        .in_data   (rx_data),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (uart_rx_ready)
    );

    // Receiver sees idle high until data transfer is enabled
    always_comb begin
        sin_next = sin_reg;
        if (!io_en) begin
            sin_next = 1'b1;
        end else if (buf_out_valid && uart_rx_ready) begin
            sin_next = buf_out_data;
        end
        dcd_next = 2'h3;
        dcd_next[port_select] = card_mode_en ? pres_f_reg : 1'b1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            io_oe_reg <= 1'b0;
            sin_reg   <= scr_pkg::RST_SIN;
            dcd_reg   <= 2'h3;
        end else begin
            io_oe_reg <= io_oe_next;
            sin_reg   <= sin_next;
            dcd_reg   <= dcd_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops except card_io_out, tied low
    // ------------------------------------------------------------------
    logic active_reg, running_reg, sin_out_reg_unused;
    logic [1:0] sin_vec_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            active_reg  <= 1'b0;
            running_reg <= 1'b0;
            sin_vec_reg <= 2'h3;
        end else begin
            active_reg  <= io_en;
            running_reg <= run;
            sin_vec_reg <= port_select ? {sin_next, 1'b1} :
                                         {1'b1, sin_next};
        end
    end

    assign sin_out_reg_unused  = buf_in_ready;
    assign card_power_switch_n = power_n_reg;
    assign card_reset          = reset_reg;
    assign card_clock          = cclk_reg;
    assign card_io_out         = 1'b0;
    assign card_io_oe          = io_oe_reg;
    assign uart_dcd_n          = dcd_reg;
    assign uart_sin            = sin_vec_reg;
    assign card_active         = active_reg;
    assign clocks_running      = running_reg;

endmodule

// >>> testbench/scr_top_sva.sv
// Concurrent checks on the card reader block ports.
// Assumes one clock domain and the active high reset of scr_top.
module scr_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Configuration
    input wire logic        card_mode_en,
    input wire logic        port_select,
    input wire logic [1:0]  card_clock_select,
    input wire logic [15:0] charge_time,
    // UART side
    input wire logic [1:0]  uart_dtr_n,
    input wire logic [1:0]  uart_rts_n,
    input wire logic [1:0]  uart_dcd_n,
    input wire logic [1:0]  uart_sin,
    // Card side and status
    input wire logic        card_present_n,
    input wire logic        card_power_switch_n,
    input wire logic        card_reset,
    input wire logic        card_clock,
    input wire logic        card_io_oe,
    input wire logic        card_active,
    input wire logic        clocks_running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic        clk_d;
    logic [1:0]  sel_d;
    logic [1:0]  tog;
    logic [15:0] run_len, prev_len;
    int          chg_cnt, stop_cnt;
    logic        tgl;
    assign tgl = card_clock != clk_d;

    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    // Level lengths, charge and stop spans
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clk_d    <= 1'b0;
            sel_d    <= 2'h0;
            tog      <= 2'h0;
            run_len  <= 16'h0000;
            prev_len <= 16'h0000;
            chg_cnt  <= 0;
            stop_cnt <= 0;
        end else begin
            clk_d <= card_clock;
            sel_d <= card_clock_select;
            run_len  <= tgl ? 16'h0001 : run_len + 16'h0001;
            prev_len <= tgl ? run_len : prev_len;
            // Skip partial levels after a source change
            if (!clocks_running || card_clock_select != sel_d) begin
                tog <= 2'h0;
            end else if (tgl && tog != 2'h3) begin
                tog <= tog + 2'h1;
            end
            chg_cnt  <= card_power_switch_n ? 0 : chg_cnt + 1;
            stop_cnt <= (card_clock_select != scr_pkg::CLKSEL_STOP) ? 0 :
                        (stop_cnt < 255) ? stop_cnt + 1 : stop_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_reset_follows;
        card_active && $past(card_active) |->
            card_reset == !$past(uart_rts_n[port_select]);
    endproperty
    a_reset_follows: assert property (p_reset_follows)
        else $error("reset vs rts");
    property p_power_gate;
        card_power_switch_n |-> !card_clock && !card_reset && !card_io_oe;
    endproperty
    a_power_gate: assert property (p_power_gate)
        else $error("live unpowered");
    property p_release_order;
        $rose(card_power_switch_n) |->
            $past(!card_reset && !card_io_oe && !card_clock);
    endproperty
    a_release_order: assert property (p_release_order)
        else $error("early release");
    property p_clk_first;
        $rose(card_active) |-> $past(clocks_running);
    endproperty
    a_clk_first: assert property (p_clk_first)
        else $error("data before clock");
    property p_charge;
        $rose(clocks_running) && !card_active |->
            chg_cnt >= 200 * int'(charge_time) &&
            chg_cnt <= 200 * (int'(charge_time) + 3);
    endproperty
    a_charge: assert property (p_charge)
        else $error("charge time");
    property p_deact;
        card_active && uart_dtr_n[port_select] |->
            ##[1:3] (!card_reset && !card_clock) ##[1:3] card_power_switch_n;
    endproperty
    a_deact: assert property (p_deact)
        else $error("no deactivation");
    property p_presence;
        (card_mode_en && $stable(card_present_n) && $stable(port_select))[*6]
            |-> uart_dcd_n[port_select] == card_present_n;
    endproperty
    a_presence: assert property (p_presence)
        else $error("dcd vs presence");
    property p_other_port;
        ($stable(port_select))[*3] |->
            uart_dcd_n[~port_select] && uart_sin[~port_select];
    endproperty
    a_other_port: assert property (p_other_port)
        else $error("other port");
    property p_idle;
        card_power_switch_n && $past(card_power_switch_n, 3) |->
            !clocks_running;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle clock");
    property p_stop;
        stop_cnt > 100 |-> $stable(card_clock);
    endproperty
    a_stop: assert property (p_stop)
        else $error("card clock not stopped");
    property p_duty;
        tgl && tog >= 2'h2 |-> 10 * ((run_len > prev_len) ?
            run_len - prev_len : prev_len - run_len) <= run_len + prev_len;
    endproperty
    a_duty: assert property (p_duty)
        else $error("bad duty");
endmodule

bind scr_top scr_chk u_chk (.*);

// >>> testbench/scr_card_model.sv
// Card in its socket: presence switch and a reset answer on the line.
// Assumes the bench resolves the pulled-up I/O line.
module scr_card_model #(
    parameter int ATR_DLY  = 400,
    parameter int BIT_CLKS = 372
) (
    // Socket control from the bench
    input wire logic inserted,
    // Contacts from the reader
    input wire logic card_power_switch_n,
    input wire logic card_reset,
    input wire logic card_clock,
    // Contacts to the reader
    output logic     card_present_n,
    output logic     card_pull_low
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Switch grounds on insertion
    assign card_present_n = !inserted;
    // Card clocks since reset release
    always @(posedge card_clock) begin
        cnt <= (card_power_switch_n || !card_reset) ? 0 : cnt + 1;
    end
    // Start bit of answer; silent unpowered
    assign card_pull_low = inserted && !card_power_switch_n &&
        card_reset && cnt >= ATR_DLY &&
        cnt < ATR_DLY + BIT_CLKS;
endmodule

// >>> testbench/scr_top_tb.sv
// Self-checking bench for the card reader block.
// Assumes the checker arrives by bind from its own file.
module scr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [1:0] sel;
        logic [7:0] div;
        int         period;
    } scr_row_s;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       card_mode_en, port_select, uart_rx_ready, inserted;
    logic [1:0] card_clock_select, uart_sout, uart_dtr_n, uart_rts_n;
    logic [7:0] high_clock_divisor;
    logic [1:0] uart_dcd_n, uart_sin;
    logic       card_power_switch_n, card_reset, card_clock;
    logic       card_io_out, card_io_oe, card_active, clocks_running;
    logic       card_present_n, card_pull_low, io_line;
    int         bad_count = 0;
    int         checks = 0;
    int         n, p;
    // Periods in block cycles: 200/3.5, 200/7.1, 24 * 200/96
    scr_row_s   rows [4] = '{'{2'h1, 8'h00, 57}, '{2'h2, 8'h00, 28},
                             '{2'h3, 8'h18, 50}, '{2'h0, 8'h00, 0}};

    // Block clock at 200 MHz
    always #2.5 ref_clk = ~ref_clk;
    // Pulled-up line, low if either pulls
    assign io_line = !((card_io_oe && !card_io_out) || card_pull_low);

    scr_top dut (
        .*, .charge_time(16'h0002), .discharge_time(16'h0003),
        .card_io_in(io_line)
    );
    // Short answer keeps run brief
    scr_card_model #(.ATR_DLY(400), .BIT_CLKS(8)) card (.*);

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    // Bounded level wait, cycles in w
    task automatic wait_lvl(ref logic s, input logic v, output int w);
        w = 0;
        while (s !== v && w < 40000) begin
            @(negedge ref_clk);
            w++;
        end
    endtask
    // Card clock period; 0 if stopped
    task automatic period(output int r);
        logic q;
        int   k;
        repeat (2) begin
            k = 0;
            do begin
                q = card_clock;
                @(negedge ref_clk);
                k++;
            end while (!(card_clock && !q) && k < 300);
        end
        r = (k < 300) ? k : 0;
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    // Inputs change on falling edges
    initial begin
        card_mode_en = 1'b1;
        port_select = 1'b0;
        card_clock_select = 2'h1;
        high_clock_divisor = 8'h00;
        uart_sout = 2'h3;
        uart_dtr_n = 2'h3;
        uart_rts_n = 2'h3;
        uart_rx_ready = 1'b1;
        inserted = 1'b1;
        cyc(10);
        rst = 1'b0;
        cyc(10);
        chk(uart_dcd_n, 2'h2);
        // Sloppy driver: rts early
        uart_rts_n = 2'h2;
        uart_dtr_n = 2'h2;
        wait_lvl(clocks_running, 1'b1, n);
        chk(n >= 400 && n < 1200, 1);
        chk(card_reset, 0);
        wait_lvl(card_active, 1'b1, n);
        cyc(2);
        chk(card_reset, 1);
        // Answer with drain stalling
        n = 0;
        while (uart_sin[0] !== 1'b0 && n < 30000) begin
            uart_rx_ready = ~uart_rx_ready;
            cyc(1);
            n++;
        end
        uart_rx_ready = 1'b1;
        chk(n < 30000, 1);
        cyc(600);
        uart_sout = 2'h2;
        cyc(4);
        chk({card_io_oe, io_line}, 2'h2);
        uart_sout = 2'h3;
        cyc(4);
        chk(card_io_oe, 0);
        $display("test bring_up done");
        foreach (rows[i]) begin
            card_clock_select = rows[i].sel;
            high_clock_divisor = rows[i].div;
            cyc(100);
            period(p);
            chk(p, rows[i].period);
        end
        card_clock_select = 2'h1;
        $display("test clock_select done");
        // Drop power, re-ask in discharge
        uart_dtr_n = 2'h3;
        cyc(3);
        chk({card_reset, card_clock}, 2'h0);
        uart_dtr_n = 2'h2;
        wait_lvl(card_power_switch_n, 1'b1, n);
        wait_lvl(card_power_switch_n, 1'b0, n);
        chk(n >= 600 && n < 1400, 1);
        wait_lvl(card_active, 1'b1, n);
        inserted = 1'b0;
        cyc(12);
        chk(card_power_switch_n, 1);
        chk(uart_dcd_n, 2'h3);
        $display("test power_cycle done");
        uart_dtr_n = 2'h3;
        inserted = 1'b1;
        cyc(1000);
        port_select = 1'b1;
        uart_dtr_n = 2'h1;
        wait_lvl(card_active, 1'b1, n);
        chk(n < 2000, 1);
        chk(uart_dcd_n, 2'h1);
        uart_dtr_n = 2'h3;
        cyc(1000);
        card_mode_en = 1'b0;
        uart_dtr_n = 2'h1;
        cyc(800);
        chk(card_power_switch_n, 1);
        card_mode_en = 1'b1;
        wait_lvl(card_active, 1'b1, n);
        rst = 1'b1;
        cyc(2);
        chk({card_power_switch_n, card_reset, card_clock, card_io_oe,
             uart_dcd_n, uart_sin}, 8'h8f);
        rst = 1'b0;
        cyc(10);
        $display("test second_reset done");
        wrap_up();
    end

    // Watchdog, about three times the run
    initial begin
        repeat (90000) @(posedge ref_clk);
        bad_count++;
        wrap_up();
    end
endmodule
